//--- verilog/rtca_alarm.sv
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
module rtca_alarm import rtca_pkg::*; #(
  parameter int DIV = RTCA_OSC_DIV
) (
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic osc_in,
  input wire logic [RTCA_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [RTCA_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq_out,
  output logic alarm_match_out
);
  typedef enum logic [2:0] {
    RTCA_W_IDLE = 3'b001,
    RTCA_W_DO = 3'b010,
    RTCA_W_RESP = 3'b100
  } rtca_wstate_t;

  rtca_wstate_t wstate_r;
  logic [RTCA_ADDR_W-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic aw_have_r;
  logic w_have_r;
  logic [RTCA_HIGH_W-1:0] alarm_time_high_r;
  logic [RTCA_LOW_W-1:0] alarm_time_low_r;
  logic [7:0] subsecond_count_r;
  logic [31:0] seconds_r;
  logic [1:0] ctl_r;
  logic [RTCA_INT_W-1:0] int_status_r;
  logic [RTCA_INT_W-1:0] int_mask_r;
  logic [2:0] busy_cnt_r;
  logic tick_w;
  logic rollover_w;
  logic busy_w;
  logic run_w;
  logic alarm_en_w;
  logic [RTCA_ALARM_W-1:0] alarm_value_w;
  logic match_w;
  logic wr_go_w;
  logic wr_ok_w;
  logic [7:0] wr_idx_w;
  logic [31:0] rd_data_w;
  logic rd_ok_w;

  // Word index from byte address
  function automatic logic [7:0] rtca_idx(input logic [RTCA_ADDR_W-1:0] a);
    rtca_idx = a[9:2];
  endfunction

  // Whether an index names a mapped register; holes in the index range answer with an error both ways
  function automatic logic rtca_mapped(input logic [7:0] i);
    rtca_mapped = (i == RTCA_IDX_SUBSECOND) || (i == RTCA_IDX_SECONDS_HIGH) || (i == RTCA_IDX_SECONDS_LOW)
                  || (i == RTCA_IDX_ALARM_HIGH) || (i == RTCA_IDX_ALARM_LOW) || (i == RTCA_IDX_CONTROL)
                  || (i == RTCA_IDX_INT_STATUS) || (i == RTCA_IDX_INT_MASK);
  endfunction

  assign run_w = ctl_r[RTCA_CTL_RUN_BIT];
  assign alarm_en_w = ctl_r[RTCA_CTL_ALARM_EN_BIT];
  assign busy_w = (busy_cnt_r != 3'h0);
  assign alarm_value_w = {alarm_time_high_r, alarm_time_low_r};

  rtca_tick_div #(.DIV(DIV)) u_tick (
    .core_clk_in(core_clk_in),
    .resetn_in(resetn_in),
    .osc_in(osc_in),
    .run_in(run_w),
    .tick_out(tick_w)
  );

  // Subsecond rollover at the tick that wraps the 8-bit counter
  assign rollover_w = tick_w && (subsecond_count_r == 8'hFF);
  // Compare against seconds as they stand at the rollover, before increment
  assign match_w = rollover_w && (alarm_value_w == seconds_r[RTCA_ALARM_W-1:0]);

  // Write channel acceptance: address and data in either order
  assign s_axi_awready = (wstate_r == RTCA_W_IDLE) && !aw_have_r;
  assign s_axi_wready = (wstate_r == RTCA_W_IDLE) && !w_have_r;
  assign wr_go_w = (wstate_r == RTCA_W_DO);
  assign wr_idx_w = rtca_idx(awaddr_r);
  assign wr_ok_w = rtca_mapped(wr_idx_w);

  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      wstate_r <= RTCA_W_IDLE;
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= 32'h0;
      wstrb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RTCA_RESP_OKAY;
    end else begin
      case (wstate_r)
        RTCA_W_IDLE: begin
          if (s_axi_awvalid && s_axi_awready) begin
            awaddr_r <= s_axi_awaddr;
            aw_have_r <= 1'b1;
          end
          if (s_axi_wvalid && s_axi_wready) begin
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
            w_have_r <= 1'b1;
          end
          if ((aw_have_r || s_axi_awvalid) && (w_have_r || s_axi_wvalid)) begin
            wstate_r <= RTCA_W_DO;
          end
        end
        RTCA_W_DO: begin
          aw_have_r <= 1'b0;
          w_have_r <= 1'b0;
          s_axi_bvalid <= 1'b1;
          s_axi_bresp <= wr_ok_w ? RTCA_RESP_OKAY : RTCA_RESP_SLVERR;
          wstate_r <= RTCA_W_RESP;
        end
        RTCA_W_RESP: begin
          if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            wstate_r <= RTCA_W_IDLE;
          end
        end
        default: wstate_r <= RTCA_W_IDLE;
      endcase
    end
  end

  // Alarm registers: no reset term, contents survive all resets
  always_ff @(posedge core_clk_in) begin
    if (wr_go_w && wr_idx_w == RTCA_IDX_ALARM_HIGH && wstrb_r[0] && (!alarm_en_w || !run_w)) begin
      alarm_time_high_r <= wdata_r[RTCA_HIGH_W-1:0];
    end
    if (wr_go_w && wr_idx_w == RTCA_IDX_ALARM_LOW && !busy_w && (!alarm_en_w || !run_w)) begin
      if (wstrb_r[0]) begin
        alarm_time_low_r[7:0] <= wdata_r[7:0];
      end
      if (wstrb_r[1]) begin
        alarm_time_low_r[15:8] <= wdata_r[15:8];
      end
    end
  end

  // Time counters: battery backed, so no reset; writable only when stopped and idle
  always_ff @(posedge core_clk_in) begin
    if (wr_go_w && !run_w && !busy_w && wr_idx_w == RTCA_IDX_SUBSECOND) begin
      subsecond_count_r <= wdata_r[7:0];
    end else if (tick_w) begin
      subsecond_count_r <= subsecond_count_r + 8'h01;
    end
    if (wr_go_w && !run_w && !busy_w && wr_idx_w == RTCA_IDX_SECONDS_LOW) begin
      seconds_r[15:0] <= wdata_r[15:0];
    end else if (wr_go_w && !run_w && !busy_w && wr_idx_w == RTCA_IDX_SECONDS_HIGH) begin
      seconds_r[31:16] <= wdata_r[15:0];
    end else if (rollover_w) begin
      seconds_r <= seconds_r + 32'h1;
    end
  end

  // Busy spans a few cycles after each run enable change, modelling the slow-domain update
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      busy_cnt_r <= 3'h0;
    end else if (wr_go_w && wr_idx_w == RTCA_IDX_CONTROL && wstrb_r[0]
                 && wdata_r[RTCA_CTL_RUN_BIT] != run_w) begin
      busy_cnt_r <= 3'(RTCA_BUSY_CYCLES);
    end else if (busy_w) begin
      busy_cnt_r <= busy_cnt_r - 3'h1;
    end
  end

  // Control and mask registers
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      ctl_r <= RTCA_CTL_RESET;
      int_mask_r <= RTCA_MASK_RESET;
    end else if (wr_go_w && wstrb_r[0]) begin
      if (wr_idx_w == RTCA_IDX_CONTROL) begin
        ctl_r <= wdata_r[1:0];
      end else if (wr_idx_w == RTCA_IDX_INT_MASK) begin
        int_mask_r <= wdata_r[RTCA_INT_W-1:0];
      end
    end
  end

  // Sticky alarm flag; a set in the clearing cycle wins
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      int_status_r <= '0;
    end else if (match_w && alarm_en_w) begin
      int_status_r[RTCA_INT_ALARM_BIT] <= 1'b1;
    end else if (wr_go_w && wstrb_r[0] && wr_idx_w == RTCA_IDX_INT_STATUS) begin
      int_status_r <= int_status_r & ~wdata_r[RTCA_INT_W-1:0];
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      irq_out <= 1'b0;
      alarm_match_out <= 1'b0;
    end else begin
      irq_out <= |(int_status_r & int_mask_r);
      alarm_match_out <= match_w && alarm_en_w;
    end
  end

  // Read mux
  always_comb begin
    rd_data_w = 32'h0;
    rd_ok_w = 1'b1;
    if (rtca_idx(s_axi_araddr) == RTCA_IDX_ALARM_HIGH) begin
      rd_data_w = {28'h0, alarm_time_high_r};
    end else if (rtca_idx(s_axi_araddr) == RTCA_IDX_ALARM_LOW) begin
      rd_data_w = {16'h0, alarm_time_low_r};
    end else if (rtca_idx(s_axi_araddr) == RTCA_IDX_SUBSECOND) begin
      rd_data_w = {24'h0, subsecond_count_r};
    end else if (rtca_idx(s_axi_araddr) == RTCA_IDX_SECONDS_HIGH) begin
      rd_data_w = {16'h0, seconds_r[31:16]};
    end else if (rtca_idx(s_axi_araddr) == RTCA_IDX_SECONDS_LOW) begin
      rd_data_w = {16'h0, seconds_r[15:0]};
    end else if (rtca_idx(s_axi_araddr) == RTCA_IDX_CONTROL) begin
      rd_data_w = {29'h0, busy_w, ctl_r};
    end else if (rtca_idx(s_axi_araddr) == RTCA_IDX_INT_STATUS) begin
      rd_data_w = {31'h0, int_status_r};
    end else if (rtca_idx(s_axi_araddr) == RTCA_IDX_INT_MASK) begin
      rd_data_w = {31'h0, int_mask_r};
    end else begin
      rd_ok_w = 1'b0;
    end
  end

  assign s_axi_arready = !s_axi_rvalid;

  // Read answer one cycle after the address is taken
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RTCA_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_data_w;
      s_axi_rresp <= rd_ok_w ? RTCA_RESP_OKAY : RTCA_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Alarm pulse: only at a rollover, with the alarm on and the value matching
  alarm_only_rollover_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    alarm_match_out |-> $past(rollover_w) && $past(alarm_en_w))
    else $error("alarm pulse without rollover");
  alarm_value_match_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    alarm_match_out |-> $past(alarm_value_w) == $past(seconds_r[19:0]))
    else $error("alarm pulse without matching seconds");
  match_pulse_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    alarm_match_out |=> !alarm_match_out)
    else $error("alarm pulse longer than one cycle");
  // Alarm halves: locked writes leave them alone, open writes land
  high_locked_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    (alarm_en_w && run_w) |=> $stable(alarm_time_high_r))
    else $error("high alarm changed while locked");
  high_write_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    (wr_go_w && wr_idx_w == RTCA_IDX_ALARM_HIGH && wstrb_r[0] && !(alarm_en_w && run_w))
    |=> alarm_time_high_r == $past(wdata_r[RTCA_HIGH_W-1:0]))
    else $error("open high alarm write lost");
  low_locked_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    (busy_w || (alarm_en_w && run_w)) |=> $stable(alarm_time_low_r))
    else $error("low alarm changed while locked");
  low_write_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    (wr_go_w && wr_idx_w == RTCA_IDX_ALARM_LOW && wstrb_r[0] && !busy_w && !(alarm_en_w && run_w))
    |=> alarm_time_low_r[7:0] == $past(wdata_r[7:0]))
    else $error("open low alarm write lost");
  high_upper_zero_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    (s_axi_arvalid && s_axi_arready && rtca_idx(s_axi_araddr) == RTCA_IDX_ALARM_HIGH)
    |=> s_axi_rdata[31:4] == 28'h0)
    else $error("high alarm upper bits not zero");
  // Counters: seconds move only at a rollover while running, subseconds at each tick
  seconds_step_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    (rollover_w && !wr_go_w) |=> seconds_r == $past(seconds_r) + 32'h1)
    else $error("seconds did not advance on rollover");
  seconds_locked_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    (run_w && !rollover_w) |=> $stable(seconds_r))
    else $error("seconds changed while running without rollover");
  subsecond_step_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    (tick_w && !wr_go_w) |=> subsecond_count_r == $past(subsecond_count_r) + 8'h01)
    else $error("subsecond did not advance on tick");
  tick_needs_run_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    tick_w |-> $past(run_w))
    else $error("tick while stopped");
  busy_count_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    (busy_w && !(wr_go_w && wr_idx_w == RTCA_IDX_CONTROL)) |=> busy_cnt_r == $past(busy_cnt_r) - 3'h1)
    else $error("busy count did not step down");
  // Status flag: set by an enabled match, dropped only by a write of one
  status_sticky_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    (match_w && alarm_en_w) |=> int_status_r[RTCA_INT_ALARM_BIT])
    else $error("alarm status not set");
  status_hold_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    (int_status_r[0] && !(wr_go_w && wr_idx_w == RTCA_IDX_INT_STATUS)) |=> int_status_r[0])
    else $error("alarm status dropped without clear");
  status_clear_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    (int_status_r[0] && wr_go_w && wr_idx_w == RTCA_IDX_INT_STATUS && wstrb_r[0] && wdata_r[0]
     && !(match_w && alarm_en_w)) |=> !int_status_r[0])
    else $error("alarm status not cleared");
  status_quiet_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    (!int_status_r[0] && !(match_w && alarm_en_w)) |=> !int_status_r[0])
    else $error("alarm status set without match");
  // Bus answers: unmapped places are refused, and each answer is handed over once
  read_unmapped_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    (s_axi_arvalid && s_axi_arready && !rtca_mapped(rtca_idx(s_axi_araddr)))
    |=> s_axi_rvalid && s_axi_rresp == RTCA_RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  write_unmapped_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    (wr_go_w && !wr_ok_w) |=> s_axi_bvalid && s_axi_bresp == RTCA_RESP_SLVERR)
    else $error("unmapped write not refused");
  bvalid_drop_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    (s_axi_bvalid && s_axi_bready) |=> !s_axi_bvalid)
    else $error("write answer repeated");
  rvalid_drop_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    (s_axi_rvalid && s_axi_rready) |=> !s_axi_rvalid)
    else $error("read answer repeated");
endmodule

//--- verilog/rtca_pkg.sv
package rtca_pkg;
  // Register word indexes; the byte address on the bus is four times the index
  localparam logic [7:0] RTCA_IDX_ALARM_HIGH = 8'h1E;
  localparam logic [7:0] RTCA_IDX_ALARM_LOW = 8'h1F;
  localparam logic [7:0] RTCA_IDX_SECONDS_LOW = 8'h1C;
  localparam logic [7:0] RTCA_IDX_SECONDS_HIGH = 8'h1B;
  localparam logic [7:0] RTCA_IDX_SUBSECOND = 8'h1A;
  localparam logic [7:0] RTCA_IDX_CONTROL = 8'h20;
  localparam logic [7:0] RTCA_IDX_INT_STATUS = 8'h21;
  localparam logic [7:0] RTCA_IDX_INT_MASK = 8'h22;
  localparam int RTCA_ADDR_W = 10;
  // Field positions
  localparam int RTCA_CTL_RUN_BIT = 0;
  localparam int RTCA_CTL_ALARM_EN_BIT = 1;
  localparam int RTCA_INT_ALARM_BIT = 0;
  localparam int RTCA_INT_W = 1;
  localparam int RTCA_ALARM_W = 20;
  localparam int RTCA_HIGH_W = 4;
  localparam int RTCA_LOW_W = 16;
  // Reset values of control state
  localparam logic [1:0] RTCA_CTL_RESET = 2'h0;
  localparam logic [0:0] RTCA_MASK_RESET = 1'h0;
  // Tick timing: 32.768 kHz oscillator divided by 128 gives 256 Hz
  localparam int RTCA_OSC_DIV = 128;
  localparam int RTCA_BUSY_CYCLES = 4;
  // AXI responses
  localparam logic [1:0] RTCA_RESP_OKAY = 2'h0;
  localparam logic [1:0] RTCA_RESP_SLVERR = 2'h2;
endpackage

//--- verilog/rtca_tick_div.sv
`timescale 1ns/1ps
// Synchronises the oscillator pin and divides its rising edges to a one-cycle tick
module rtca_tick_div import rtca_pkg::*; #(
  parameter int DIV = RTCA_OSC_DIV
) (
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic osc_in,
  input wire logic run_in,
  output logic tick_out
);
  logic sync1_r;
  logic sync2_r;
  logic prev_r;
  logic [$clog2(DIV)-1:0] cnt_r;
  logic edge_w;

  // Two-stage synchroniser; first stage feeds only the second
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      sync1_r <= osc_in;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end

  assign edge_w = sync2_r & ~prev_r;

  // Divider runs only while the clock is enabled
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      cnt_r <= '0;
      tick_out <= 1'b0;
    end else begin
      tick_out <= 1'b0;
      if (run_in && edge_w) begin
        if (cnt_r == ($clog2(DIV))'(DIV - 1)) begin
          cnt_r <= '0;
          tick_out <= 1'b1;
        end else begin
          cnt_r <= cnt_r + 1'b1;
        end
      end
    end
  end
endmodule

//--- bench/test_rtc_time_of_day_alarm.sv
`timescale 1ns/1ps
module test_rtc_time_of_day_alarm import rtca_pkg::*; ;
  logic core_clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic osc_in = 1'b0;
  logic [RTCA_ADDR_W-1:0] s_axi_awaddr = '0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [RTCA_ADDR_W-1:0] s_axi_araddr = '0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  logic irq_out;
  logic alarm_match_out;
  int errors = 0;
  int n_tests = 0;
  int i;
  int hits;
  logic [33:0] rd_q[$];
  logic [1:0] wr_q[$];
  logic [31:0] seed = 32'h0000002D;

  // Core clock, and an oscillator at half its rate so ticks come fast
  always #2.5 core_clk_in = ~core_clk_in;
  always @(posedge core_clk_in) osc_in <= ~osc_in;

  // Small divider keeps a whole subsecond rollover near a thousand cycles
  rtca_alarm #(.DIV(2)) i_dut (
    .core_clk_in(core_clk_in), .resetn_in(resetn_in), .osc_in(osc_in),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq_out(irq_out),
    .alarm_match_out(alarm_match_out)
  );

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  task automatic complete_run;
    if (errors == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic give_up;
    errors++;
    complete_run();
  endtask

  // Responses are matched against the oldest note when they are handed over
  always @(posedge core_clk_in) begin
    if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) chk({32'h0, s_axi_bresp}, {32'h0, wr_q.pop_front()});
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) chk({s_axi_rresp, s_axi_rdata}, rd_q.pop_front());
  end

  // Write: address and data offered together, each dropped once it is taken
  task automatic wr(input logic [7:0] idx, input logic [31:0] d, input logic [1:0] r);
    bit done;
    int n;
    done = 0;
    wr_q.push_back(r);
    @(posedge core_clk_in);
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50 && !done; n++) begin
      @(posedge core_clk_in);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) begin
        s_axi_bready <= 1'b0;
        done = 1;
      end
    end
    if (!done) give_up();
  endtask

  // Read: expected response and data are noted before the request goes out
  task automatic rd(input logic [7:0] idx, input logic [33:0] exp);
    bit done;
    int n;
    done = 0;
    rd_q.push_back(exp);
    @(posedge core_clk_in);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50 && !done; n++) begin
      @(posedge core_clk_in);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) begin
        s_axi_rready <= 1'b0;
        done = 1;
      end
    end
    if (!done) give_up();
  endtask

  // Main sequence
  initial begin
    repeat (2) @(posedge core_clk_in);
    resetn_in <= 1'b1;
    // Unmapped place answers with an error and zero data
    rd(8'hFF, {RTCA_RESP_SLVERR, 32'h0});
    wr(8'hFF, 32'h1, RTCA_RESP_SLVERR);
    // Clock stopped: both alarm halves take writes, upper high bits stay zero
    for (i = 0; i < 4; i++) begin
      seed = xs(seed);
      wr(RTCA_IDX_ALARM_HIGH, seed, RTCA_RESP_OKAY);
      wr(RTCA_IDX_ALARM_LOW, {seed[15:0], seed[31:16]}, RTCA_RESP_OKAY);
      rd(RTCA_IDX_ALARM_HIGH, {RTCA_RESP_OKAY, 28'h0, seed[3:0]});
      rd(RTCA_IDX_ALARM_LOW, {RTCA_RESP_OKAY, 16'h0, seed[31:16]});
    end
    // Seconds bits above 19 differ from zero on purpose; they must not matter
    wr(RTCA_IDX_ALARM_HIGH, 32'h5, RTCA_RESP_OKAY);
    wr(RTCA_IDX_ALARM_LOW, 32'h1234, RTCA_RESP_OKAY);
    wr(RTCA_IDX_SECONDS_HIGH, 32'hA005, RTCA_RESP_OKAY);
    wr(RTCA_IDX_SECONDS_LOW, 32'h1234, RTCA_RESP_OKAY);
    wr(RTCA_IDX_SUBSECOND, 32'hC0, RTCA_RESP_OKAY);
    wr(RTCA_IDX_INT_MASK, 32'h1, RTCA_RESP_OKAY);
    wr(RTCA_IDX_CONTROL, 32'h3, RTCA_RESP_OKAY);
    repeat (RTCA_BUSY_CYCLES + 2) @(posedge core_clk_in);
    // Running with the alarm on: writes are acknowledged but dropped
    wr(RTCA_IDX_ALARM_HIGH, 32'hA, RTCA_RESP_OKAY);
    wr(RTCA_IDX_ALARM_LOW, 32'h4321, RTCA_RESP_OKAY);
    rd(RTCA_IDX_ALARM_HIGH, {RTCA_RESP_OKAY, 32'h5});
    rd(RTCA_IDX_ALARM_LOW, {RTCA_RESP_OKAY, 32'h1234});
    for (i = 0; i < 2000 && alarm_match_out !== 1'b1; i++) @(posedge core_clk_in);
    if (i == 2000) give_up();
    @(posedge core_clk_in);
    chk({33'h0, irq_out}, 34'h1);
    rd(RTCA_IDX_INT_STATUS, {RTCA_RESP_OKAY, 32'h1});
    // Masking hides the level, unmasking shows the still-set flag again
    wr(RTCA_IDX_INT_MASK, 32'h0, RTCA_RESP_OKAY);
    repeat (3) @(posedge core_clk_in);
    chk({33'h0, irq_out}, 34'h0);
    wr(RTCA_IDX_INT_MASK, 32'h1, RTCA_RESP_OKAY);
    repeat (3) @(posedge core_clk_in);
    chk({33'h0, irq_out}, 34'h1);
    wr(RTCA_IDX_INT_STATUS, 32'h1, RTCA_RESP_OKAY);
    repeat (3) @(posedge core_clk_in);
    chk({33'h0, irq_out}, 34'h0);
    rd(RTCA_IDX_INT_STATUS, {RTCA_RESP_OKAY, 32'h0});
    rd(RTCA_IDX_SECONDS_LOW, {RTCA_RESP_OKAY, 32'h1235});
    // One more rollover falls in this window, now with seconds past the alarm
    hits = 0;
    repeat (1300) begin
      @(posedge core_clk_in);
      if (alarm_match_out === 1'b1) hits++;
    end
    chk(34'(hits), 34'h0);
    rd(RTCA_IDX_SECONDS_LOW, {RTCA_RESP_OKAY, 32'h1236});
    // Reset in mid-run must leave the alarm halves alone
    resetn_in <= 1'b0;
    repeat (2) @(posedge core_clk_in);
    resetn_in <= 1'b1;
    rd(RTCA_IDX_ALARM_HIGH, {RTCA_RESP_OKAY, 32'h5});
    rd(RTCA_IDX_ALARM_LOW, {RTCA_RESP_OKAY, 32'h1234});
    chk({33'h0, irq_out}, 34'h0);
    // Running with the alarm off: both halves take writes, the low one through its upper byte lane alone
    wr(RTCA_IDX_CONTROL, 32'h1, RTCA_RESP_OKAY);
    repeat (RTCA_BUSY_CYCLES + 2) @(posedge core_clk_in);
    wr(RTCA_IDX_ALARM_HIGH, 32'hFFFFFFF3, RTCA_RESP_OKAY);
    s_axi_wstrb <= 4'h2;
    wr(RTCA_IDX_ALARM_LOW, 32'h0000AB00, RTCA_RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    rd(RTCA_IDX_ALARM_HIGH, {RTCA_RESP_OKAY, 32'h3});
    rd(RTCA_IDX_ALARM_LOW, {RTCA_RESP_OKAY, 32'hAB34});
    complete_run();
  end
endmodule
